//--- core/dhc_pkg.sv
package dhc_pkg;
  // ----------------------------------------------------------------
  // widths and device register offsets
  // ----------------------------------------------------------------
  localparam int          DW          = 20;
  localparam int          AW          = 12;
  localparam int          TRAIL_W     = 12;
  localparam int          STAT_W      = 9;
  localparam int          SMP_W       = 16;
  localparam logic [11:0] OFF_SIS     = 12'h04F;
  localparam logic [11:0] OFF_LTRAIL  = 12'h0C5;
  localparam logic [11:0] OFF_RTRAIL  = 12'h0C6;
  localparam logic [11:0] OFF_SHADOW  = 12'h0C8;
  localparam logic [11:0] OFF_PINLVL  = 12'h0ED;
  localparam logic [11:0] OFF_CFG     = 12'h0E6;
  localparam logic [11:0] OFF_AUDIO   = 12'h0E7;
  localparam logic [11:0] OFF_RUN     = 12'h0F0;
  localparam logic [11:0] VER_BASE    = 12'hFF6;
  localparam logic [11:0] VER_LAST    = 12'hFFF;
  // ----------------------------------------------------------------
  // field layout and values
  // ----------------------------------------------------------------
  localparam logic [19:0] SIS_PRIMARY = 20'h00000;
  localparam logic [19:0] SIS_ALT     = 20'h00002;
  localparam int          CFG_DMA_BIT = 4;
  localparam int          CFG_DL_BIT  = 5;
  localparam int          AUD_MUTE    = 0;
  localparam int          AUD_TONE    = 1;
  localparam int          AUD_OUT32   = 2;
  localparam int          DEMAND_BIT  = 19;
  localparam int          ALT_DATA    = 14;
  localparam int          ALT_FRAME   = 15;
  localparam int          ALT_CLK     = 16;
  localparam int          STRAP_DMA   = 4;
  localparam logic [1:0]  LAYER_ONE   = 2'h3;
  localparam logic [1:0]  LAYER_RSVD  = 2'h0;
  localparam logic [3:0]  BR_BAD      = 4'hF;
  localparam logic [19:0] ENTRY_NEW   = 20'h00475;
  localparam logic [19:0] ENTRY_OLD   = 20'h00FCB;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ     = 125;
  localparam int          PG_DELAY_US = 10;
  localparam int          BOOT_NS     = 80;
  localparam int          BOOT_CYC    = (BOOT_NS * CLK_MHZ + 999) / 1000;
  // ----------------------------------------------------------------
  // host software port
  // ----------------------------------------------------------------
  localparam logic [2:0]  H_ADDR      = 3'h0;
  localparam logic [2:0]  H_WDATA     = 3'h1;
  localparam logic [2:0]  H_CTRL      = 3'h2;
  localparam logic [2:0]  H_STAT      = 3'h3;
  localparam logic [2:0]  H_RDATA     = 3'h4;
  localparam int          C_WR        = 0;
  localparam int          C_RD        = 1;
  localparam int          C_APPLY     = 2;
  localparam int          C_DL_ON     = 3;
  localparam int          C_DL_OFF    = 4;
  localparam int          SPACE_BIT   = 12;
  typedef enum logic [2:0] {
    HS_BOOT, HS_CLR_L, HS_CLR_R, HS_WAIT_PG, HS_IDLE, HS_XFER, HS_CAPT
  } dhc_hstate_type;
endpackage

//--- core/dhc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dhc_link_if;
  logic [11:0] addr;
  logic        space;
  logic [19:0] wdata;
  logic        wr;
  logic        rd;
  logic [19:0] rdata;
  logic        wake_run_enable;
  logic        power_good_output;
  modport dev  (input addr, space, wdata, wr, rd, wake_run_enable, output rdata, power_good_output);
  modport host (output addr, space, wdata, wr, rd, wake_run_enable, input rdata, power_good_output);
endinterface
`default_nettype wire

//--- core/dhc_pwr_seq.sv
`timescale 1ns/10ps
`default_nettype none
module dhc_pwr_seq
  import dhc_pkg::*;
#(
  parameter int DELAY_US = PG_DELAY_US
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic converter_enable_in,
  output logic      power_good_out
);
  initial begin
    if (DELAY_US < 1 || DELAY_US > 65535) $error("dhc_pwr_seq: DELAY_US out of range");
  end
  typedef struct packed {
    logic [7:0]  div;
    logic [15:0] us;
    logic        pg;
  } dhc_pwr_type;
  dhc_pwr_type s_reg, s_next;
  // ----------------------------------------------------------------
  // microsecond enable, then settle count
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (!converter_enable_in) begin
      // converter off drops power good at once
      s_next = '0;
    end else if (!s_reg.pg) begin
      if (s_reg.div == 8'(CLK_MHZ - 1)) begin
        s_next.div = '0;
        if (s_reg.us == 16'(DELAY_US - 1)) s_next.pg = 1'b1;
        else s_next.us = s_reg.us + 16'h0001;
      end else begin
        s_next.div = s_reg.div + 8'h01;
      end
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) s_reg <= '0;
    else s_reg <= s_next;
  end
  assign power_good_out = s_reg.pg;
endmodule
`default_nettype wire

//--- core/dhc_device.sv
`timescale 1ns/10ps
`default_nettype none
module dhc_device
  import dhc_pkg::*;
#(
  parameter logic [19:0]           NAME_CODE   = 20'h0A5A5,
  parameter logic [19:0]           DESIGN_CODE = 20'h00001,
  parameter logic [19:0]           TAPE_DATE   = 20'h00000,
  parameter logic [6:0][19:0]      DESC        = '0,
  parameter int                    PG_US       = PG_DELAY_US
) (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  dhc_link_if.dev                  link,
  input  wire logic                converter_enable_in,
  input  wire logic [2:0]          primary_serial_in,
  input  wire logic [19:0]         parallel_port_in,
  input  wire logic [STAT_W-1:0]   mpeg_status_in,
  input  wire logic [1:0]          stream_layer_in,
  input  wire logic [3:0]          bitrate_idx_in,
  input  wire logic                header_valid_in,
  input  wire logic [SMP_W-1:0]    sample_in,
  output logic [2:0]               serial_route_out,
  output logic                     dsp_mode_out,
  output logic [STAT_W-1:0]        port_status_out,
  output logic                     port_status_oe_out,
  output logic                     layer_ok_out,
  output logic                     sync_ok_out,
  output logic                     out32_out,
  output logic [TRAIL_W-1:0]       left_trailing_out,
  output logic [TRAIL_W-1:0]       right_trailing_out,
  output logic [SMP_W-1:0]         sample_out,
  output logic [19:0]              run_entry_out,
  output logic                     run_pulse_out,
  output logic                     download_en_out,
  output logic                     dma_mode_out
);
  // arbitrary identity values above; real parts carry their own
  initial begin
    if (SMP_W < 4) $error("dhc_device: sample width too small");
    if (PG_US < 1) $error("dhc_device: power good delay too short");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                strap_done;
    logic                alt_sel;
    logic [TRAIL_W-1:0]  ltrail;
    logic [TRAIL_W-1:0]  rtrail;
    logic [19:0]         cfg;
    logic [2:0]          audio;
    logic [19:0]         run_entry;
    logic                run_pulse;
    logic [19:0]         rdata;
    logic [2:0]          route;
    logic                dsp;
    logic [STAT_W-1:0]   stat;
    logic                stat_oe;
    logic                layer_ok;
    logic                sync_ok;
    logic [SMP_W-1:0]    smp;
  } dhc_dev_type;
  dhc_dev_type s_reg, s_next;

  logic               pg;
  logic [SMP_W-1:0]   toned;
  logic [19:0]        rd_val;
  logic [3:0]         ver_idx;

  dhc_pwr_seq #(
    .DELAY_US            (PG_US)
  ) i_dhc_pwr_seq (
    .clk_in              (clk_in),
    .rst_in              (rst_in),
    .converter_enable_in (converter_enable_in),
    .power_good_out      (pg)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  assign ver_idx = 4'(link.addr - VER_BASE);
  always_comb begin
    rd_val = '0;
    if (link.space) begin
      if (link.addr >= VER_BASE && link.addr <= VER_LAST) begin
        case (ver_idx)
          4'h0:    rd_val = NAME_CODE;
          4'h1:    rd_val = DESIGN_CODE;
          4'h2:    rd_val = TAPE_DATE;
          default: rd_val = DESC[3'(ver_idx - 4'h3)];
        endcase
      end
    end else begin
      case (link.addr)
        OFF_PINLVL: begin
          rd_val = parallel_port_in;
          rd_val[DEMAND_BIT] = 1'b0;
        end
        OFF_SHADOW: rd_val[DEMAND_BIT] = parallel_port_in[DEMAND_BIT];
        OFF_CFG:    rd_val = s_reg.cfg;
        OFF_AUDIO:  rd_val = {17'h00000, s_reg.audio};
        OFF_RUN:    rd_val = s_reg.run_entry;
        default:    rd_val = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // audio path
  // ----------------------------------------------------------------
  // tone stage is a fixed cut; it never overflows, so no clipping logic
  assign toned = s_reg.audio[AUD_TONE] ?
                 SMP_W'(sample_in - SMP_W'($signed(sample_in) >>> 2)) : sample_in;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.run_pulse = 1'b0;
    // strap caught on the first clock after reset release
    // a cfg write on that same edge lands after the strap and wins
    if (!s_reg.strap_done) begin
      s_next.strap_done = 1'b1;
      s_next.cfg[CFG_DMA_BIT] = parallel_port_in[STRAP_DMA];
    end
    if (link.wr && !link.space) begin
      case (link.addr)
        OFF_SIS: begin
          if (link.wdata == SIS_PRIMARY) s_next.alt_sel = 1'b0;
          else if (link.wdata == SIS_ALT) s_next.alt_sel = 1'b1;
          // any other value is reserved and ignored
        end
        OFF_LTRAIL: s_next.ltrail = link.wdata[TRAIL_W-1:0];
        OFF_RTRAIL: s_next.rtrail = link.wdata[TRAIL_W-1:0];
        OFF_CFG:    s_next.cfg = link.wdata; // download bit kept by host
        OFF_AUDIO:  s_next.audio = link.wdata[2:0];
        OFF_RUN: begin
          s_next.run_entry = link.wdata;
          s_next.run_pulse = 1'b1;
        end
        default: s_next.alt_sel = s_reg.alt_sel;
      endcase
    end
    s_next.rdata = link.rd ? rd_val : '0;
    // alternate pins feed the decoder straight, no mux outside
    s_next.route = s_reg.alt_sel ?
                   {parallel_port_in[ALT_CLK], parallel_port_in[ALT_FRAME], parallel_port_in[ALT_DATA]} :
                   primary_serial_in;
    s_next.dsp = link.wake_run_enable;
    // low pins belong to the DMA data path in that mode
    s_next.stat_oe = !s_reg.cfg[CFG_DMA_BIT];
    s_next.stat = s_reg.cfg[CFG_DMA_BIT] ? '0 : mpeg_status_in;
    s_next.layer_ok = header_valid_in && stream_layer_in != LAYER_ONE && stream_layer_in != LAYER_RSVD;
    // every legal rate index counts, the lowest included
    s_next.sync_ok = header_valid_in && bitrate_idx_in != BR_BAD;
    s_next.smp = s_reg.audio[AUD_MUTE] ? '0 : toned;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) s_reg <= '0;
    else s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.rdata             = s_reg.rdata;
  // power good is the sequencer's own flop, passed straight on
  assign link.power_good_output = pg;
  assign serial_route_out       = s_reg.route;
  assign dsp_mode_out           = s_reg.dsp;
  assign port_status_out        = s_reg.stat;
  assign port_status_oe_out     = s_reg.stat_oe;
  assign layer_ok_out           = s_reg.layer_ok;
  assign sync_ok_out            = s_reg.sync_ok;
  assign out32_out              = s_reg.audio[AUD_OUT32];
  assign left_trailing_out      = s_reg.ltrail;
  assign right_trailing_out     = s_reg.rtrail;
  assign sample_out             = s_reg.smp;
  assign run_entry_out          = s_reg.run_entry;
  assign run_pulse_out          = s_reg.run_pulse;
  assign download_en_out        = s_reg.cfg[CFG_DL_BIT];
  assign dma_mode_out           = s_reg.cfg[CFG_DMA_BIT];
endmodule
`default_nettype wire

//--- core/dhc_host.sv
`timescale 1ns/10ps
`default_nettype none
module dhc_host
  import dhc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [2:0]  sw_addr_in,
  input  wire logic [19:0] sw_wdata_in,
  input  wire logic        sw_wr_in,
  input  wire logic        sw_rd_in,
  output logic [19:0]      sw_rdata_out,
  dhc_link_if.host         link
);
  typedef struct packed {
    dhc_hstate_type st;
    logic [7:0]     boot;
    logic [12:0]    addr;
    logic [19:0]    wdata;
    logic [19:0]    cfg;
    logic [19:0]    rdata;
    logic [19:0]    sw_rdata;
    logic [11:0]    lk_addr;
    logic           lk_space;
    logic [19:0]    lk_wdata;
    logic           lk_wr;
    logic           lk_rd;
    logic           wake;
  } dhc_host_type;
  dhc_host_type s_reg, s_next;
  logic busy;

  assign busy = s_reg.st != HS_IDLE;

  // ----------------------------------------------------------------
  // start-up sequence and command engine
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.lk_wr = 1'b0;
    s_next.lk_rd = 1'b0;
    s_next.sw_rdata = '0;
    case (s_reg.st)
      HS_BOOT: begin
        if (s_reg.boot == 8'(BOOT_CYC - 1)) s_next.st = HS_CLR_L;
        else s_next.boot = s_reg.boot + 8'h01;
      end
      HS_CLR_L: begin
        s_next.lk_wr = 1'b1;
        s_next.lk_space = 1'b0;
        s_next.lk_addr = OFF_LTRAIL;
        s_next.lk_wdata = '0;
        s_next.st = HS_CLR_R;
      end
      HS_CLR_R: begin
        s_next.lk_wr = 1'b1;
        s_next.lk_addr = OFF_RTRAIL;
        s_next.st = HS_WAIT_PG;
      end
      HS_WAIT_PG: begin
        // wake only once running and the converter reports good
        if (link.power_good_output) begin
          s_next.wake = 1'b1;
          s_next.st = HS_IDLE;
        end
      end
      HS_XFER: s_next.st = s_reg.lk_rd ? HS_CAPT : HS_IDLE;
      HS_CAPT: begin
        s_next.rdata = link.rdata;
        s_next.st = HS_IDLE;
      end
      default: s_next.st = HS_IDLE;
    endcase
    if (sw_wr_in) begin
      case (sw_addr_in)
        H_ADDR:  s_next.addr = sw_wdata_in[12:0];
        H_WDATA: s_next.wdata = sw_wdata_in;
        H_CTRL: begin
          // orders while busy are dropped; software polls the busy bit
          if (!busy) begin
            s_next.st = HS_XFER;
            s_next.lk_space = s_reg.addr[SPACE_BIT];
            s_next.lk_addr = s_reg.addr[11:0];
            s_next.lk_wdata = s_reg.wdata;
            if (sw_wdata_in[C_RD]) begin
              s_next.lk_rd = 1'b1;
            end else if (sw_wdata_in[C_APPLY]) begin
              s_next.lk_wr = 1'b1;
              s_next.lk_space = 1'b0;
              s_next.lk_addr = OFF_RUN;
              s_next.lk_wdata = ENTRY_NEW;
            end else if (sw_wdata_in[C_DL_ON] || sw_wdata_in[C_DL_OFF]) begin
              s_next.lk_wr = 1'b1;
              s_next.lk_space = 1'b0;
              s_next.lk_addr = OFF_CFG;
              s_next.lk_wdata = s_reg.cfg;
              s_next.lk_wdata[CFG_DL_BIT] = sw_wdata_in[C_DL_ON];
              s_next.cfg[CFG_DL_BIT] = sw_wdata_in[C_DL_ON];
            end else if (sw_wdata_in[C_WR]) begin
              s_next.lk_wr = 1'b1;
              if (!s_reg.addr[SPACE_BIT] && s_reg.addr[11:0] == OFF_CFG) s_next.cfg = s_reg.wdata;
            end else begin
              s_next.st = HS_IDLE;
            end
          end
        end
        default: s_next.addr = s_reg.addr;
      endcase
    end
    if (sw_rd_in) begin
      case (sw_addr_in)
        H_ADDR:  s_next.sw_rdata = {7'h00, s_reg.addr};
        H_WDATA: s_next.sw_rdata = s_reg.wdata;
        H_STAT:  s_next.sw_rdata = {16'h0000, s_reg.cfg[CFG_DL_BIT], link.power_good_output, s_reg.wake, busy};
        H_RDATA: s_next.sw_rdata = s_reg.rdata;
        default: s_next.sw_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) s_reg <= '{st: HS_BOOT, default: '0};
    else s_reg <= s_next;
  end

  assign sw_rdata_out         = s_reg.sw_rdata;
  assign link.addr            = s_reg.lk_addr;
  assign link.space           = s_reg.lk_space;
  assign link.wdata           = s_reg.lk_wdata;
  assign link.wr              = s_reg.lk_wr;
  assign link.rd              = s_reg.lk_rd;
  assign link.wake_run_enable = s_reg.wake;
endmodule
`default_nettype wire

//--- core/dummy_end_marker_unused.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- testbench/dhc_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dhc_link_sva
  import dhc_pkg::*;
#(
  parameter logic [19:0] NAME_CODE = 20'h0A5A5
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [11:0] addr,
  input  wire logic        space,
  input  wire logic [19:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [19:0] rdata,
  input  wire logic        wake_run_enable,
  input  wire logic        power_good_output
);
  // ----------------------------------------------------------------
  // link checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_strobe_excl: assert property (!(wr && rd))
    else $error("link read and write strobes together");
  a_rd_single: assert property (rd |=> !rd)
    else $error("link read strobe longer than one cycle");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 20'h00000)
    else $error("read data outside its cycle");
  a_wake_after_pgood: assert property ($rose(wake_run_enable) |-> power_good_output && $past(power_good_output))
    else $error("wake raised without power good");
  a_version_name: assert property (rd && space && addr == VER_BASE |=> rdata == NAME_CODE)
    else $error("name cell read wrong");
  a_demand_hidden: assert property (rd && !space && addr == OFF_PINLVL |=> !rdata[DEMAND_BIT])
    else $error("demand pin shown in pin levels");
  a_boot_trail_zero: assert property (wr && !space && !wake_run_enable
      && (addr == OFF_LTRAIL || addr == OFF_RTRAIL) |-> wdata[11:0] == 12'h000)
    else $error("trailing bits not zeroed at start");
  a_apply_entry: assert property (wr && !space && addr == OFF_RUN |-> wdata == ENTRY_NEW)
    else $error("run issued at old entry");
endmodule
`default_nettype wire

//--- testbench/test_decoder_host_config_registers.sv
`timescale 1ns/10ps
`default_nettype none
module test_decoder_host_config_registers
  import dhc_pkg::*;
;
  // identity values are arbitrary
  localparam logic [19:0]      T_NAME   = 20'h0A1B2;
  localparam logic [19:0]      T_DESIGN = 20'h00042;
  localparam logic [19:0]      T_DATE   = 20'h01234;
  localparam logic [6:0][19:0] T_DESC   = {20'h00066, 20'h00055, 20'h00044, 20'h00033, 20'h00022, 20'h00011, 20'h00009};
  logic        clk_in = 1'h0;
  logic        rst_in = 1'h1;
  logic [2:0]  sw_addr = 3'h0;
  logic [19:0] sw_wdata = 20'h00000;
  logic        sw_wr = 1'h0;
  logic        sw_rd = 1'h0;
  logic [19:0] sw_rdata;
  logic        conv_en = 1'h0;
  logic [2:0]  prim = 3'h5;
  logic [19:0] pp = 20'h8A5C3;
  logic [8:0]  mstat = 9'h1A5;
  logic [1:0]  layer = 2'h2;
  logic [3:0]  bidx = 4'h1;
  logic        hv = 1'h1;
  logic [15:0] smp = 16'h4000;
  logic [2:0]  route;
  logic [8:0]  pstat;
  logic [11:0] ltr, rtr;
  logic [15:0] smp_out;
  logic [19:0] entry, v;
  logic        dsp, poe, lok, sok, out32, rpulse, dl_en, dma;
  int          bad_count = 0;
  int          tests_run = 0;
  int          pulses = 0;
  int          trail_clr = 0;
  int          n;
  logic [19:0] aud_val [3] = '{20'h00007, 20'h00006, 20'h00004};
  logic [15:0] aud_exp [3] = '{16'h0000, 16'h3000, 16'h4000};

  always #4 clk_in = ~clk_in;
  // counted mid-cycle, away from the edge that launches them
  always @(negedge clk_in) if (rpulse === 1'h1) pulses++;
  always @(negedge clk_in) if (link.wr === 1'h1 && link.space === 1'h0 && link.wake_run_enable === 1'h0
                               && (link.addr == OFF_LTRAIL || link.addr == OFF_RTRAIL)) trail_clr++;

  // ----------------------------------------------------------------
  // the two ends and the checker
  // ----------------------------------------------------------------
  dhc_link_if link ();
  dhc_device #(.NAME_CODE(T_NAME), .DESIGN_CODE(T_DESIGN), .TAPE_DATE(T_DATE), .DESC(T_DESC), .PG_US(1)) i_dhc_device (
    .clk_in(clk_in), .rst_in(rst_in), .link(link), .converter_enable_in(conv_en), .primary_serial_in(prim),
    .parallel_port_in(pp), .mpeg_status_in(mstat), .stream_layer_in(layer), .bitrate_idx_in(bidx),
    .header_valid_in(hv), .sample_in(smp), .serial_route_out(route), .dsp_mode_out(dsp),
    .port_status_out(pstat), .port_status_oe_out(poe), .layer_ok_out(lok), .sync_ok_out(sok),
    .out32_out(out32), .left_trailing_out(ltr), .right_trailing_out(rtr), .sample_out(smp_out),
    .run_entry_out(entry), .run_pulse_out(rpulse), .download_en_out(dl_en), .dma_mode_out(dma));
  dhc_host i_dhc_host (
    .clk_in(clk_in), .rst_in(rst_in), .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr),
    .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata), .link(link));
  dhc_link_sva #(.NAME_CODE(T_NAME)) i_dhc_link_sva (
    .clk_in(clk_in), .rst_in(rst_in), .addr(link.addr), .space(link.space), .wdata(link.wdata),
    .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .wake_run_enable(link.wake_run_enable),
    .power_good_output(link.power_good_output));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic sw_write(input logic [2:0] a, input logic [19:0] d);
    @(posedge clk_in);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'h1;
    @(posedge clk_in);
    sw_wr <= 1'h0;
  endtask
  task automatic sw_read(input logic [2:0] a, output logic [19:0] d);
    @(posedge clk_in);
    sw_addr <= a;
    sw_rd <= 1'h1;
    @(posedge clk_in);
    sw_rd <= 1'h0;
    #1;
    d = sw_rdata;
  endtask
  // busy polling is bounded; a stuck host is left to the watchdog
  task automatic link_op(input int op, input logic [19:0] a, input logic [19:0] d);
    logic [19:0] s;
    int k;
    sw_write(H_ADDR, a);
    sw_write(H_WDATA, d);
    sw_write(H_CTRL, 20'h00001 << op);
    s = 20'h00001;
    k = 0;
    while (s[0] !== 1'h0 && k < 40) begin
      sw_read(H_STAT, s);
      k++;
    end
    repeat (2) @(posedge clk_in);
  endtask
  task automatic lread(input logic [19:0] a, output logic [19:0] d);
    link_op(C_RD, a, 20'h00000);
    sw_read(H_RDATA, d);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    complete_run;
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'h0;
    repeat (40) @(posedge clk_in);
    sw_read(H_STAT, v);
    check("wake before power", v[1], 1'h0);
    check("dsp mode idle", dsp, 1'h0);
    @(posedge clk_in) conv_en <= 1'h1;
    n = 0;
    while (v[1] !== 1'h1 && n < 400) begin
      sw_read(H_STAT, v);
      n++;
    end
    repeat (2) @(posedge clk_in);
    check("power good", v[2], 1'h1);
    check("dsp mode", dsp, 1'h1);
    check("left trailing boot", ltr, 12'h000);
    check("right trailing boot", rtr, 12'h000);
    check("trailing clears", 20'(trail_clr), 20'h00002);
    // reserved select values must leave the last routing in place
    for (int i = 0; i < 4; i++) begin
      link_op(C_WR, {8'h00, OFF_SIS}, 20'(2 - i + 2 * (i / 3)));
      check("serial route", route, (i < 2) ? {pp[ALT_CLK], pp[ALT_FRAME], pp[ALT_DATA]} : prim);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in) pp <= {i[0], 19'h0A5C3};
      lread({8'h00, OFF_PINLVL}, v);
      check("pin levels", v, {1'h0, 19'h0A5C3});
      lread({8'h00, OFF_SHADOW}, v);
      check("demand shadow", v[DEMAND_BIT], i[0]);
    end
    lread({8'h00, 12'h0A0}, v);
    check("unmapped read", v, 20'h00000);
    // a write into the version cells must be ignored
    link_op(C_WR, {7'h00, 1'h1, VER_BASE}, 20'h12345);
    for (int i = 0; i < 10; i++) begin
      lread({7'h00, 1'h1, 12'(VER_BASE + i)}, v);
      check("version cell", v, (i == 0) ? T_NAME : (i == 1) ? T_DESIGN : (i == 2) ? T_DATE : T_DESC[i - 3]);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in) layer <= 2'(i);
      bidx <= (i == 3) ? BR_BAD : 4'h1;
      repeat (3) @(posedge clk_in);
      check("layer ok", lok, (i == 1 || i == 2));
      check("low rate sync", sok, i != 3);
    end
    link_op(C_WR, {8'h00, OFF_LTRAIL}, 20'hFFABC);
    link_op(C_WR, {8'h00, OFF_RTRAIL}, 20'hFF123);
    check("left trailing", ltr, 12'hABC);
    check("right trailing", rtr, 12'h123);
    lread({8'h00, OFF_LTRAIL}, v);
    check("trailing write only", v, 20'h00000);
    for (int i = 0; i < 3; i++) begin
      link_op(C_WR, {8'h00, OFF_AUDIO}, aud_val[i]);
      check("out32 mode", out32, 1'h1);
      check("mute with tone", smp_out, aud_exp[i]);
    end
    for (int i = 0; i < 2; i++) begin
      link_op(C_WR, {8'h00, OFF_CFG}, i ? 20'h00000 : 20'h00010);
      check("dma mode", dma, i == 0);
      check("status enable", poe, i != 0);
      check("status pins", pstat, i ? 9'h1A5 : 9'h000);
    end
    link_op(C_DL_ON, 20'h00000, 20'h00000);
    check("download on", dl_en, 1'h1);
    lread({8'h00, OFF_CFG}, v);
    check("download cfg bit", v[CFG_DL_BIT], 1'h1);
    link_op(C_DL_OFF, 20'h00000, 20'h00000);
    check("download off", dl_en, 1'h0);
    link_op(C_APPLY, 20'h00000, 20'h00000);
    check("run entry", entry, ENTRY_NEW);
    check("run pulses", 20'(pulses), 20'h00001);
    complete_run;
  end
endmodule
`default_nettype wire
